//--- verilog/acs_regs.svh
// register offsets, field positions, reset values and timing counts of the scan sequencer
`ifndef ACS_REGS_SVH
`define ACS_REGS_SVH

// register addresses on the special function register bus
`define ACS_ADDR_PINS      8'hc7
`define ACS_ADDR_CTRL      8'hd7
`define ACS_ADDR_SELECT    8'he7
`define ACS_ADDR_RES_LOW0  8'hc8
`define ACS_ADDR_RES_HIGH  8'hd0

// control register fields
`define ACS_CTRL_PRE_HI    7
`define ACS_CTRL_PRE_LO    6
`define ACS_CTRL_RSVD      5
`define ACS_CTRL_DONE      4
`define ACS_CTRL_START     3
`define ACS_CTRL_CONT      2
`define ACS_CTRL_RISE      1
`define ACS_CTRL_FALL      0

// reset values
`define ACS_CTRL_RESET     8'h00
`define ACS_SELECT_RESET   8'h00

// timing, in conversion clock periods (one period = m machine cycles / 2)
`define ACS_SAMPLE_BITS    4'h2
`define ACS_RESULT_BITS    4'ha
`define ACS_NUM_CHANNELS   8

`endif

//--- verilog/acs_pkg.sv
// types shared by the scan sequencer files
package acs_pkg;

   // one-hot sequencer states
   typedef enum logic [4:0] {
      ACS_IDLE   = 5'b00001,
      ACS_INIT   = 5'b00010,
      ACS_SAMPLE = 5'b00100,
      ACS_CONV   = 5'b01000,
      ACS_STORE  = 5'b10000
   } acs_state_t;

   // register bus request
   typedef struct packed {
      logic       rd;
      logic       wr;
      logic [7:0] addr;
      logic [7:0] wdata;
   } acs_bus_req_t;

   // analog front end control
   typedef struct packed {
      logic [2:0] channel;
      logic       sample;
      logic [9:0] trial;
   } acs_afe_t;

endpackage : acs_pkg

//--- verilog/acs_prescaler.sv
// conversion clock prescaler: one tick every m/2 machine cycles
`timescale 1ns/1ps
`default_nettype none
module acs_prescaler (
   input  wire logic       mclk_in,
   input  wire logic       rstn_in,
   input  wire logic       run_in,
   input  wire logic [1:0] sel_in,
   output logic            tick_out
);
   import acs_pkg::*;

   logic [1:0] cnt_reg;
   logic [1:0] last;

   // half divisor minus one: codes 00..11 give m = 2,4,6,8
   assign last     = sel_in;
   assign tick_out = run_in && (cnt_reg >= last);

   ////////////////////////////////////////////////////////////////////
   // free counter, held clear while stopped so the clock is halted
   always_ff @(posedge mclk_in) begin
      if (!rstn_in || !run_in) begin
         cnt_reg <= 2'h0;
      end else if (cnt_reg >= last) begin
         cnt_reg <= 2'h0;
      end else begin
         cnt_reg <= cnt_reg + 2'h1;
      end
   end
endmodule : acs_prescaler
`default_nettype wire

//--- verilog/acs_sequencer.sv
// autoscan sequencer for a ten bit successive approximation converter
// What this block does
// - empty channel select blocks starts from rest; continuous restart scans channel 0
// - new selection applies from next loop
// - results read-only, kept over reset
// - low byte read latches top bits
// - high register: latch bits 0-1, rest zero
// - pin register shows live pins, read-only
// - reset clears control and channel select
// - low power aborts, clears start, stops clock
// - low power leaves done flag alone
// - conversion lasts 6m+1 machine cycles
// - sample two bits, ten bits, store
// - init slot gives 7m per channel
// - start delay varies with clock phase
// - scan lowest to highest selected channel
// - start by software or selected pin edge
// - loop end sets done flag
// - continuous restarts; one-time stops, clears start
// - start pending while done flag set
// - prescale codes give divisor 2,4,6,8
// - starts ignored while start flag set
// - software clearing start aborts conversion
// - software cannot set done flag
`timescale 1ns/1ps
`default_nettype none
`include "acs_regs.svh"
module acs_sequencer (
   input  wire logic                  mclk_in,
   input  wire logic                  rstn_in,
   input  wire acs_pkg::acs_bus_req_t bus_in,
   output logic [7:0]                 rdata_out,
   input  wire logic [7:0]            pins_in,
   input  wire logic                  ext_start_in,
   input  wire logic                  low_power_in,
   input  wire logic                  comp_in,
   output acs_pkg::acs_afe_t          afe_out,
   output logic                       irq_out
);
   import acs_pkg::*;

   ////////////////////////////////////////////////////////////////////
   // declarations
   acs_state_t  state_reg;
   logic [7:0]  ctrl_reg;
   logic [7:0]  select_reg;
   logic [7:0]  loop_sel_reg;
   logic        start_reg;
   logic        pending_reg;
   logic        done_reg;
   logic [2:0]  chan_reg;
   logic [3:0]  phase_reg;
   logic [9:0]  sar_reg;
   logic [9:0]  bitmask_reg;
   logic [1:0]  high_latch_reg;
   logic [9:0]  result_mem [0:`ACS_NUM_CHANNELS-1];
   logic [7:0]  pins_s1_reg;
   logic [7:0]  pins_s2_reg;
   logic [2:0]  ext_s_reg;
   logic        lp_s1_reg;
   logic        lp_s2_reg;
   logic        tick;
   logic        ext_edge;
   logic        wr_ctrl;
   logic        sw_set;
   logic        start_req;
   logic        go;
   logic        abort;
   logic        res_rd;
   logic        is_last;
   logic [2:0]  next_chan;
   logic [2:0]  first_chan;
   logic        run;
   logic        loop_end;

   // lowest set channel at or above a position, used for first and next channel
   function automatic logic [2:0] find_from(input logic [7:0] sel, input logic [3:0] from);
      logic [2:0] pick;
      pick = 3'h0;
      for (int i = 7; i >= 0; i--) begin
         if (sel[i] && (4'(i) >= from)) begin
            pick = 3'(i);
         end
      end
      return pick;
   endfunction : find_from

   // true when any channel is selected at or above a position
   function automatic logic any_from(input logic [7:0] sel, input logic [3:0] from);
      logic hit;
      hit = 1'b0;
      for (int i = 0; i < 8; i++) begin
         if (sel[i] && (4'(i) >= from)) begin
            hit = 1'b1;
         end
      end
      return hit;
   endfunction : any_from

   ////////////////////////////////////////////////////////////////////
   // pin synchronisers: pins, external start and low power come from outside
   always_ff @(posedge mclk_in) begin
      pins_s1_reg <= pins_in;
      pins_s2_reg <= pins_s1_reg;
      lp_s1_reg   <= low_power_in;
      lp_s2_reg   <= lp_s1_reg;
      ext_s_reg   <= {ext_s_reg[1:0], ext_start_in};
   end

   // edge detection looks only at synchronised stages 1 and 2
   assign ext_edge = (ctrl_reg[`ACS_CTRL_RISE] && ext_s_reg[1] && !ext_s_reg[2]) ||
                     (ctrl_reg[`ACS_CTRL_FALL] && !ext_s_reg[1] && ext_s_reg[2]);

   assign wr_ctrl   = bus_in.wr && (bus_in.addr == `ACS_ADDR_CTRL);
   assign sw_set    = wr_ctrl && bus_in.wdata[`ACS_CTRL_START];
   assign start_req = sw_set || ext_edge;
   // starts only from rest, with the done flag clear and channels selected
   assign go        = (pending_reg || start_req) && !start_reg && !done_reg
                      && (select_reg != 8'h00) && !lp_s2_reg;
   // software clearing start or low power entry kills the scan
   assign abort     = lp_s2_reg ||
                      (wr_ctrl && !bus_in.wdata[`ACS_CTRL_START] && start_reg);
   // divider runs free outside low power so a start lands on its current phase
   assign run       = !lp_s2_reg;

   assign first_chan = find_from(loop_sel_reg, 4'h0);
   assign is_last    = !any_from(loop_sel_reg, 4'({1'b0, chan_reg}) + 4'h1);
   assign next_chan  = find_from(loop_sel_reg, 4'({1'b0, chan_reg}) + 4'h1);
   // second store tick of the final selected channel closes the loop
   assign loop_end   = (state_reg == ACS_STORE) && tick && (phase_reg == 4'h1)
                       && is_last && !abort;

   ////////////////////////////////////////////////////////////////////
   // conversion clock; a start waits for the next tick, up to m/2 cycles
   acs_prescaler u_pre (
      .mclk_in  (mclk_in),
      .rstn_in  (rstn_in),
      .run_in   (run),
      .sel_in   ({ctrl_reg[`ACS_CTRL_PRE_HI], ctrl_reg[`ACS_CTRL_PRE_LO]}),
      .tick_out (tick)
   );

   ////////////////////////////////////////////////////////////////////
   // control register: prescale, mode and edge enables; reserved bit kept zero
   always_ff @(posedge mclk_in) begin
      if (!rstn_in) begin
         ctrl_reg   <= `ACS_CTRL_RESET;
         select_reg <= `ACS_SELECT_RESET;
      end else begin
         if (wr_ctrl) begin
            ctrl_reg <= bus_in.wdata & 8'hc7;
         end
         if (bus_in.wr && (bus_in.addr == `ACS_ADDR_SELECT)) begin
            select_reg <= bus_in.wdata;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // start flag, pending start and done flag
   always_ff @(posedge mclk_in) begin
      if (!rstn_in) begin
         start_reg   <= 1'b0;
         pending_reg <= 1'b0;
         done_reg    <= 1'b0;
      end else begin
         // a start while done is held back until software clears done
         if (go) begin
            pending_reg <= 1'b0;
         end else if (start_req && done_reg && !start_reg) begin
            pending_reg <= 1'b1;
         end else if (lp_s2_reg || (wr_ctrl && !bus_in.wdata[`ACS_CTRL_START])) begin
            pending_reg <= 1'b0;
         end
         if (go) begin
            start_reg <= 1'b1;
         end else if (abort) begin
            start_reg <= 1'b0;
         end else if (loop_end && !ctrl_reg[`ACS_CTRL_CONT]) begin
            start_reg <= 1'b0;
         end
         // set wins over a same-cycle clear; software may only clear
         if (loop_end) begin
            done_reg <= 1'b1;
         end else if (wr_ctrl && !bus_in.wdata[`ACS_CTRL_DONE]) begin
            done_reg <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // sequencer: init, two-tick sample, ten bit ticks, store.
   // tick period is m/2 cycles, so a channel is 14 ticks = 7m cycles
   always_ff @(posedge mclk_in) begin
      if (!rstn_in || abort) begin
         state_reg   <= ACS_IDLE;
         chan_reg    <= 3'h0;
         phase_reg   <= 4'h0;
         sar_reg     <= 10'h000;
         bitmask_reg <= 10'h000;
         loop_sel_reg <= 8'h00;
      end else begin
         case (state_reg)
            ACS_IDLE: begin
               if (go) begin
                  loop_sel_reg <= select_reg;
                  state_reg    <= ACS_INIT;
               end
            end
            ACS_INIT: begin
               if (tick) begin
                  chan_reg  <= first_chan;
                  phase_reg <= 4'h0;
                  state_reg <= ACS_SAMPLE;
               end
            end
            ACS_SAMPLE: begin
               if (tick) begin
                  if (phase_reg == `ACS_SAMPLE_BITS - 4'h1) begin
                     phase_reg   <= 4'h0;
                     sar_reg     <= 10'h200;
                     bitmask_reg <= 10'h200;
                     state_reg   <= ACS_CONV;
                  end else begin
                     phase_reg <= phase_reg + 4'h1;
                  end
               end
            end
            ACS_CONV: begin
               if (tick) begin
                  // keep the trial bit if the input is above the trial level
                  sar_reg <= (comp_in ? sar_reg : (sar_reg & ~bitmask_reg))
                             | (bitmask_reg >> 1);
                  bitmask_reg <= bitmask_reg >> 1;
                  if (phase_reg == `ACS_RESULT_BITS - 4'h1) begin
                     phase_reg <= 4'h0;
                     state_reg <= ACS_STORE;
                  end else begin
                     phase_reg <= phase_reg + 4'h1;
                  end
               end
            end
            ACS_STORE: begin
               // result written on first cycle here, the rest of the slot is the init period
               // two ticks here make the channel slot 14 ticks, i.e. 7m cycles
               if (tick) begin
                  if (phase_reg == 4'h0) begin
                     phase_reg <= 4'h1;
                  end else begin
                     phase_reg <= 4'h0;
                     if (!is_last) begin
                        chan_reg  <= next_chan;
                        state_reg <= ACS_SAMPLE;
                     end else if (ctrl_reg[`ACS_CTRL_CONT]) begin
                        loop_sel_reg <= select_reg;
                        chan_reg     <= find_from(select_reg, 4'h0);
                        state_reg    <= ACS_SAMPLE;
                     end else begin
                        state_reg <= ACS_IDLE;
                     end
                  end
               end
            end
            default: begin
               state_reg <= ACS_IDLE;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////
   // result buffers: no reset, so contents survive chip reset
   logic store_now;
   logic store_done_reg;
   assign store_now = (state_reg == ACS_STORE) && !store_done_reg && !abort;
   always_ff @(posedge mclk_in) begin
      if (!rstn_in) begin
         store_done_reg <= 1'b0;
      end else begin
         store_done_reg <= (state_reg == ACS_STORE);
      end
   end
   always_ff @(posedge mclk_in) begin
      if (store_now) begin
         result_mem[chan_reg] <= sar_reg;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // coherent high bits: any low byte read copies that result's top bits
   assign res_rd = bus_in.rd && (bus_in.addr[7:3] == 5'(`ACS_ADDR_RES_LOW0 >> 3));
   always_ff @(posedge mclk_in) begin
      if (res_rd) begin
         high_latch_reg <= result_mem[bus_in.addr[2:0]][9:8];
      end
   end

   ////////////////////////////////////////////////////////////////////
   // read data, registered; start shows the effective status, not a pending one
   always_ff @(posedge mclk_in) begin
      if (!rstn_in) begin
         rdata_out <= 8'h00;
      end else if (bus_in.rd) begin
         if (res_rd) begin
            rdata_out <= result_mem[bus_in.addr[2:0]][7:0];
         end else begin
            case (bus_in.addr)
               `ACS_ADDR_PINS:     rdata_out <= pins_s2_reg;
               `ACS_ADDR_CTRL:     rdata_out <= {ctrl_reg[7:5], done_reg, start_reg,
                                                 ctrl_reg[2:0]};
               `ACS_ADDR_SELECT:   rdata_out <= select_reg;
               `ACS_ADDR_RES_HIGH: rdata_out <= {6'h00, high_latch_reg};
               default:            rdata_out <= 8'h00;
            endcase
         end
      end
   end

   assign irq_out = done_reg;
   // trial level sits at the current sar value with the tested bit set
   assign afe_out = '{channel: chan_reg, sample: (state_reg == ACS_SAMPLE), trial: sar_reg};

   ////////////////////////////////////////////////////////////////////
   // assertions
   sequence s_store;
      loop_end;
   endsequence

   AST_EMPTY_NO_START: assert property (@(posedge mclk_in) disable iff (!rstn_in)
      (select_reg == 8'h00 && !start_reg) |=> !start_reg)
      else $error("start taken with no channel selected");
   AST_DONE_SET: assert property (@(posedge mclk_in) disable iff (!rstn_in)
      s_store |=> done_reg)
      else $error("done flag not set at loop end");
   AST_ONETIME_STOP: assert property (@(posedge mclk_in) disable iff (!rstn_in)
      (s_store and !ctrl_reg[`ACS_CTRL_CONT]) |=> !start_reg ##1 state_reg == ACS_IDLE)
      else $error("one-time scan did not stop");
   AST_CONT_KEEP: assert property (@(posedge mclk_in) disable iff (!rstn_in)
      (s_store and (ctrl_reg[`ACS_CTRL_CONT] && !go)) |=> start_reg)
      else $error("continuous scan dropped start");
   AST_LP_ABORT: assert property (@(posedge mclk_in) disable iff (!rstn_in)
      lp_s2_reg |=> !start_reg && state_reg == ACS_IDLE)
      else $error("low power did not abort");
   AST_HOLD_WHILE_DONE: assert property (@(posedge mclk_in) disable iff (!rstn_in)
      (done_reg && !start_reg) |=> !start_reg)
      else $error("start taken while done set");
   AST_NO_SW_DONE: assert property (@(posedge mclk_in) disable iff (!rstn_in)
      (!done_reg && !loop_end) |=> !done_reg)
      else $error("done flag set without loop end");
   AST_SW_ABORT: assert property (@(posedge mclk_in) disable iff (!rstn_in)
      (wr_ctrl && !bus_in.wdata[`ACS_CTRL_START] && start_reg) |=> state_reg == ACS_IDLE)
      else $error("software clear did not abort");
   AST_HIGH_ZERO: assert property (@(posedge mclk_in) disable iff (!rstn_in)
      (bus_in.rd && bus_in.addr == `ACS_ADDR_RES_HIGH) |=> rdata_out[7:2] == 6'h00)
      else $error("high register upper bits not zero");
endmodule : acs_sequencer
`default_nettype wire

//--- verification/acs_afe_model.sv
// analog front end model: eight held input levels and the trial comparator
`timescale 1ns/1ps
`default_nettype none
module acs_afe_model (
   input  wire acs_pkg::acs_afe_t afe_in,
   input  wire logic [79:0]       levels_in,
   output logic                   comp_out
);
   import acs_pkg::*;

   ////////////////////////////////////////////////////////////
   // comparator follows the selected channel live, so a trial word changed
   // mid-period is judged at once, no settling help is given to the sequencer
   assign comp_out = (levels_in[afe_in.channel * 10 +: 10] >= afe_in.trial);

endmodule : acs_afe_model
`default_nettype wire

//--- verification/test_acs_sequencer.sv
// self-checking bench for the autoscan sequencer
`timescale 1ns/1ps
`default_nettype none
`include "acs_regs.svh"
module test_acs_sequencer;
   import acs_pkg::*;
   localparam int LIMIT = 20000;

   logic         mclk_in      = 1'b0;
   logic         rstn_in      = 1'b0;
   acs_bus_req_t bus_in       = '0;
   logic [7:0]   rdata_out;
   logic [7:0]   pins_in      = 8'h00;
   logic         ext_start_in = 1'b0;
   logic         low_power_in = 1'b0;
   logic         comp_in;
   acs_afe_t     afe_out;
   logic         irq_out;
   logic [79:0]  levels       = '0;
   logic         rd_d         = 1'b0;
   logic         rd_d2        = 1'b0;
   logic         smp_d        = 1'b0;
   logic [7:0]   exp_rd[$];
   logic [2:0]   exp_ch[$];
   int           cyc          = 0;
   int           failures     = 0;
   int           total_checks = 0;
   int           t0;
   int           t1;
   int           t2;

   ////////////////////////////////////////////////////////////
   // clock, 20 ns period
   always #10 mclk_in = ~mclk_in;

   acs_sequencer dut (
      .mclk_in      (mclk_in),
      .rstn_in      (rstn_in),
      .bus_in       (bus_in),
      .rdata_out    (rdata_out),
      .pins_in      (pins_in),
      .ext_start_in (ext_start_in),
      .low_power_in (low_power_in),
      .comp_in      (comp_in),
      .afe_out      (afe_out),
      .irq_out      (irq_out)
   );

   acs_afe_model afe (
      .afe_in    (afe_out),
      .levels_in (levels),
      .comp_out  (comp_in)
   );

   ////////////////////////////////////////////////////////////
   task automatic chk(input string what, input logic [15:0] e, input logic [15:0] g);
      total_checks++;
      if (g !== e) begin
         failures++;
         $display("Error %s expected %h seen %h", what, e, g);
      end
   endtask : chk

   task automatic complete_run();
      $display("checks %0d failures %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : complete_run

   // one strobe cycle, released at the edge that takes it
   task automatic bus(input logic r, input logic w, input logic [7:0] a, input logic [7:0] d);
      @(posedge mclk_in);
      bus_in <= {r, w, a, d};
      @(posedge mclk_in);
      bus_in <= '0;
   endtask : bus

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      bus(1'b0, 1'b1, a, d);
   endtask : wr

   task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
      exp_rd.push_back(e);
      bus(1'b1, 1'b0, a, 8'h00);
   endtask : rd_chk

   // low byte first so the high latch belongs to the same result
   task automatic rd_res(input logic [2:0] n);
      logic [9:0] lv;
      lv = levels[n * 10 +: 10];
      rd_chk(`ACS_ADDR_RES_LOW0 + {5'h00, n}, lv[7:0]);
      rd_chk(`ACS_ADDR_RES_HIGH, {6'h00, lv[9:8]});
   endtask : rd_res

   task automatic wait_irq();
      int n;
      n = 0;
      while (irq_out !== 1'b1 && n < 3000) begin
         @(negedge mclk_in);
         n++;
      end
      chk("irq raised", 16'h0001, {15'h0000, irq_out});
   endtask : wait_irq

   task automatic wait_smp(output int t);
      int n;
      n = 0;
      do begin
         @(negedge mclk_in);
         n++;
      end while (!(afe_out.sample === 1'b1 && smp_d !== 1'b1) && n < 3000);
      t = cyc;
   endtask : wait_smp

   ////////////////////////////////////////////////////////////
   // monitor: read data lands one cycle after the strobe edge, so it is
   // compared two edges after the request was visible
   always @(posedge mclk_in) begin
      rd_d  <= bus_in.rd;
      rd_d2 <= rd_d;
      smp_d <= afe_out.sample;
   end

   always @(negedge mclk_in) begin
      if (rd_d2 && exp_rd.size() > 0) begin
         chk("read data", {8'h00, exp_rd.pop_front()}, {8'h00, rdata_out});
      end
      if (afe_out.sample === 1'b1 && smp_d !== 1'b1 && exp_ch.size() > 0) begin
         chk("channel", {13'h0000, exp_ch.pop_front()}, {13'h0000, afe_out.channel});
      end
   end

   // hang guard
   always @(posedge mclk_in) begin
      cyc <= cyc + 1;
      if (cyc == LIMIT) begin
         failures++;
         complete_run();
      end
   end

   ////////////////////////////////////////////////////////////
   initial begin
      void'($urandom(32'h3b74bbef));
      for (int i = 0; i < 8; i++) begin
         levels[i * 10 +: 10] = 10'($urandom);
      end
      repeat (4) @(posedge mclk_in);
      pins_in <= 8'($urandom);
      repeat (4) @(posedge mclk_in);
      rstn_in <= 1'b1;
      rd_chk(`ACS_ADDR_CTRL, 8'h00);
      rd_chk(`ACS_ADDR_SELECT, 8'h00);
      rd_chk(8'h00, 8'h00);
      rd_chk(`ACS_ADDR_PINS, pins_in);
      wr(`ACS_ADDR_CTRL, 8'h08);
      rd_chk(`ACS_ADDR_CTRL, 8'h00);
      // one-time scan, selection changed to channel 1 mid-loop
      wr(`ACS_ADDR_SELECT, 8'h05);
      exp_ch.push_back(3'h0);
      exp_ch.push_back(3'h2);
      exp_ch.push_back(3'h1);
      wr(`ACS_ADDR_CTRL, 8'h08);
      wait_smp(t1);
      wr(`ACS_ADDR_SELECT, 8'h02);
      wait_smp(t2);
      chk("scan cycle", 16'h000e, 16'(t2 - t1));
      rd_chk(`ACS_ADDR_PINS, pins_in);
      wait_irq();
      rd_chk(`ACS_ADDR_CTRL, 8'h10);
      wr(`ACS_ADDR_CTRL, 8'h18);
      rd_chk(`ACS_ADDR_CTRL, 8'h10);
      rd_res(3'h0);
      rd_res(3'h2);
      wr(`ACS_ADDR_RES_LOW0 + 8'h02, 8'h55);
      wr(`ACS_ADDR_CTRL, 8'h08);
      rd_chk(`ACS_ADDR_CTRL, 8'h08);
      wait_irq();
      rd_res(3'h1);
      // reset after the run keeps the result buffers
      @(posedge mclk_in);
      rstn_in <= 1'b0;
      repeat (8) @(posedge mclk_in);
      rstn_in <= 1'b1;
      rd_chk(`ACS_ADDR_CTRL, 8'h00);
      rd_chk(`ACS_ADDR_SELECT, 8'h00);
      rd_res(3'h2);
      // continuous scan, then low power
      wr(`ACS_ADDR_SELECT, 8'h05);
      wr(`ACS_ADDR_CTRL, 8'h0c);
      wait_irq();
      rd_chk(`ACS_ADDR_CTRL, 8'h1c);
      @(posedge mclk_in);
      low_power_in <= 1'b1;
      repeat (6) @(posedge mclk_in);
      rd_chk(`ACS_ADDR_CTRL, 8'h14);
      chk("done kept", 16'h0001, {15'h0000, irq_out});
      rd_res(3'h0);
      @(posedge mclk_in);
      low_power_in <= 1'b0;
      wr(`ACS_ADDR_CTRL, 8'h00);
      // every prescaler code, then abort by software
      wr(`ACS_ADDR_SELECT, 8'h03);
      for (int c = 0; c < 4; c++) begin
         exp_ch.push_back(3'h0);
         exp_ch.push_back(3'h1);
         wr(`ACS_ADDR_CTRL, {c[1:0], 6'h08});
         @(negedge mclk_in);
         t0 = cyc;
         wait_smp(t1);
         chk("start delay", 16'h0001, 16'((t1 - t0 >= 1) && (t1 - t0 <= c + 1)));
         wait_smp(t2);
         chk("scan cycle", 16'(14 * (c + 1)), 16'(t2 - t1));
         wr(`ACS_ADDR_CTRL, {c[1:0], 6'h00});
         rd_chk(`ACS_ADDR_CTRL, {c[1:0], 6'h00});
         repeat (120) @(posedge mclk_in);
         chk("no done after abort", 16'h0000, {15'h0000, irq_out});
      end
      // external start edges: rising, falling, none
      wr(`ACS_ADDR_SELECT, 8'h01);
      wr(`ACS_ADDR_CTRL, 8'h02);
      @(posedge mclk_in);
      ext_start_in <= 1'b1;
      wait_irq();
      rd_chk(`ACS_ADDR_CTRL, 8'h12);
      wr(`ACS_ADDR_CTRL, 8'h01);
      @(posedge mclk_in);
      ext_start_in <= 1'b0;
      wait_irq();
      rd_chk(`ACS_ADDR_CTRL, 8'h11);
      wr(`ACS_ADDR_CTRL, 8'h00);
      @(posedge mclk_in);
      ext_start_in <= 1'b1;
      repeat (40) @(posedge mclk_in);
      ext_start_in <= 1'b0;
      repeat (40) @(posedge mclk_in);
      wr(`ACS_ADDR_CTRL, 8'h10);
      rd_chk(`ACS_ADDR_CTRL, 8'h00);
      repeat (4) @(posedge mclk_in);
      chk("channels left", 16'h0000, 16'(exp_ch.size()));
      complete_run();
   end

endmodule : test_acs_sequencer
`default_nettype wire
